// File: core/exec_pkg.sv
// Purpose: Shared constants and types for the 8-bit execute datapath.
// Assumes: Decoder presents one instruction with operands already read.
// Notes: Status flags live in one byte, one bit per flag.
//
// Contract
// - Add registers, optional carry in, flags ZCNVH, 1 cycle
// - Word add immediate to pair, flags ZCNVS, 2 cycles
// - Word subtract immediate from pair, ZCNVS, 2 cycles
// - Subtract register or constant, flags ZCNVH, 1 cycle
// - Subtract with carry also removes carry, 1 cycle
// - AND OR XOR update only ZNV, 1 cycle
// - Bit clear ANDs 0xFF minus constant; set ORs
// - Test ANDs register with itself, ZNV, 1 cycle
// - Multiplies put product in R1:R0, ZC, 2 cycles
// - Fractional multiplies shift product left one bit
// - Indirect jump loads PC from Z, 2 cycles
// - Indirect call saves return, PC from Z, 3 cycles
// - Compare-skip on equal, flags kept, 1/2/3 cycles
// - Compares discard result, update ZNVCH, 1 cycle
// - Skip when selected register bit is clear
// - Skip when selected register bit is set
package exec_pkg;
  // Widths
  localparam int DATA_W = 8;
  localparam int PC_W = 16;
  localparam int WORD_K_W = 6;
  localparam int REG_ADDR_W = 2;
  // Flag positions in the status byte
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  // Which flags each class of instruction may change
  localparam logic [7:0] MASK_ARITH = 8'h2f;
  localparam logic [7:0] MASK_WORD = 8'h1f;
  localparam logic [7:0] MASK_LOGIC = 8'h0e;
  localparam logic [7:0] MASK_MULT = 8'h03;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hff;
  // Cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  // Program counter steps
  localparam logic [15:0] PC_STEP_ONE = 16'h0001;
  localparam logic [15:0] PC_STEP_TWO = 16'h0002;
  localparam logic [15:0] PC_STEP_THREE = 16'h0003;
  // Register port map
  localparam logic [1:0] REG_SREG = 2'h0;
  localparam logic [1:0] REG_CTRL = 2'h1;
  localparam logic [1:0] REG_PC_LO = 2'h2;
  localparam logic [1:0] REG_PC_HI = 2'h3;
  localparam int CTRL_HALT = 0;
  // Reset values
  localparam logic [7:0] SREG_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD_REGS, OP_ADD_CARRY, OP_WORD_ADD_IMM, OP_WORD_SUB_IMM,
    OP_SUB_REGS, OP_SUB_CONST, OP_SUB_REGS_BORROW, OP_SUB_CONST_BORROW,
    OP_BITAND_REGS, OP_BITAND_CONST, OP_BITOR_REGS, OP_BITOR_CONST,
    OP_BITXOR_REGS, OP_BITS_SET, OP_BITS_CLEAR, OP_ZERO_MINUS_TEST,
    OP_MULT_UNSIGNED, OP_MULT_SIGNED, OP_MULT_MIXED, OP_FRAC_MULT_UNSIGNED,
    OP_FRAC_MULT_SIGNED, OP_FRAC_MULT_MIXED, OP_INDIRECT_JUMP, OP_INDIRECT_CALL,
    OP_COMPARE_SKIP_EQUAL, OP_COMPARE_REGS, OP_COMPARE_BORROW, OP_COMPARE_IMM,
    OP_SKIP_BIT_CLEAR, OP_SKIP_BIT_SET
  } op_e;

  typedef enum logic [1:0] {WB_NONE, WB_BYTE, WB_PAIR, WB_PROD} wb_e;

  // Packs flag values into status byte positions
  function automatic logic [7:0] mk_flags(input logic h, input logic s, input logic v,
                                          input logic n, input logic z, input logic c);
    logic [7:0] f;
    f = 8'h00;
    f[FLAG_H] = h;
    f[FLAG_S] = s;
    f[FLAG_V] = v;
    f[FLAG_N] = n;
    f[FLAG_Z] = z;
    f[FLAG_C] = c;
    return f;
  endfunction : mk_flags
endpackage : exec_pkg

// File: core/flag_alu.sv
// Purpose: Byte adder/subtractor with carry, half-carry and overflow.
// Assumes: Subtraction means a minus b minus carryIn.
// Notes: Purely combinational.
module flag_alu #(
  parameter int W = 8
) (
  // Operands
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic carryIn,
  input wire logic subtract,
  // Results
  output logic [W-1:0] result,
  output logic carryOut,
  output logic halfOut,
  output logic overflowOut
);
  // Refuse widths the nibble carry cannot serve
  if (W < 8) begin : g_bad_width
    $error("flag_alu needs at least 8 bits");
  end
  logic [W-1:0] bEff;
  logic cEff;
  logic [W:0] sum;
  logic [4:0] low;
  // Subtract as a + ~b + ~borrow
  always_comb begin
    bEff = subtract ? ~b : b;
    cEff = subtract ? ~carryIn : carryIn;
    sum = {1'b0, a} + {1'b0, bEff} + (W+1)'(cEff);
    low = {1'b0, a[3:0]} + {1'b0, bEff[3:0]} + 5'(cEff);
    result = sum[W-1:0];
    carryOut = sum[W] ^ subtract;
    halfOut = low[4] ^ subtract;
    overflowOut = (a[W-1] == bEff[W-1]) && (sum[W-1] != a[W-1]);
  end
endmodule : flag_alu

// File: core/mult_unit.sv
// Purpose: Signed, unsigned and mixed byte multiply with fraction shift.
// Assumes: aSigned and bSigned pick operand signedness.
// Notes: Carry is product top bit taken before the fraction shift.
module mult_unit #(
  parameter int W = 8
) (
  // Operands
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic aSigned,
  input wire logic bSigned,
  input wire logic frac,
  // Results
  output logic [2*W-1:0] product,
  output logic carry,
  output logic zero
);
  // Refuse widths the fraction shift cannot serve
  if (W < 2) begin : g_bad_width
    $error("mult_unit width too small");
  end
  logic signed [W:0] aExt;
  logic signed [W:0] bExt;
  logic signed [2*W+1:0] full;
  logic [2*W-1:0] raw;
  // Extend by one bit so mixed signedness shares one multiplier
  always_comb begin
    aExt = $signed({aSigned & a[W-1], a});
    bExt = $signed({bSigned & b[W-1], b});
    full = aExt * bExt;
    raw = full[2*W-1:0];
    carry = raw[2*W-1];
    product = frac ? {raw[2*W-2:0], 1'b0} : raw;
    zero = (product == '0);
  end
endmodule : mult_unit

// File: core/exec_unit.sv
// Purpose: Execute stage for arithmetic, logic, multiply, jump and skip.
// Assumes: Decoder holds issue one cycle with operands valid beside it.
// Notes: Register file write-back and return stack live outside.
//
// Chosen here: the address map and the strobed register port.
module exec_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Instruction issue
  input wire logic issue,
  input wire exec_pkg::op_e opcode,
  input wire logic [7:0] rd,
  input wire logic [7:0] rr,
  input wire logic [7:0] rdHigh,
  input wire logic [15:0] zPtr,
  input wire logic [2:0] bitSel,
  input wire logic nextIsTwoWord,
  // Register port
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Results
  output logic ready,
  output logic wbValid,
  output exec_pkg::wb_e wbKind,
  output logic [15:0] wbData,
  output logic [15:0] pc,
  output logic [7:0] sreg,
  output logic pushValid,
  output logic [15:0] pushAddr
);
  typedef struct packed {
    exec_pkg::wb_e kind;
    logic [15:0] data;
    logic [7:0] mask;
    logic [7:0] vals;
    logic [15:0] pc;
    logic push;
    logic [15:0] ret;
  } res_s;

  typedef struct packed {
    logic busy;
    logic [1:0] cnt;
    res_s pend;
    logic ready;
    logic wbValid;
    exec_pkg::wb_e wbKind;
    logic [15:0] wbData;
    logic [15:0] pc;
    logic [7:0] sreg;
    logic [7:0] ctrl;
    logic pushValid;
    logic [15:0] pushAddr;
    logic [7:0] regRdata;
  } st_s;

  st_s s;
  st_s next_s;
  logic [1:0] rstPipe;
  logic rstSync;
  logic take;
  res_s dec;
  res_s fin;
  logic [1:0] decCyc;
  logic [7:0] aluB;
  logic aluCin;
  logic aluSub;
  logic [7:0] aluRes;
  logic aluC;
  logic aluH;
  logic aluV;
  logic mulASigned;
  logic mulBSigned;
  logic mulFrac;
  logic [15:0] mulProd;
  logic mulC;
  logic mulZ;
  logic [15:0] pairIn;
  logic [15:0] wordK;
  logic [15:0] wordRes;
  logic [7:0] logicRes;

  // Reset release through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync = rstPipe[1];

  assign take = issue && s.ready;

  flag_alu #(.W(exec_pkg::DATA_W)) u_alu (
    .a(rd),
    .b(aluB),
    .carryIn(aluCin),
    .subtract(aluSub),
    .result(aluRes),
    .carryOut(aluC),
    .halfOut(aluH),
    .overflowOut(aluV)
  );

  mult_unit #(.W(exec_pkg::DATA_W)) u_mult (
    .a(rd),
    .b(rr),
    .aSigned(mulASigned),
    .bSigned(mulBSigned),
    .frac(mulFrac),
    .product(mulProd),
    .carry(mulC),
    .zero(mulZ)
  );

  // Operand steering for adder and multiplier
  always_comb begin
    aluB = rr;
    aluCin = 1'b0;
    aluSub = 1'b0;
    mulASigned = 1'b0;
    mulBSigned = 1'b0;
    mulFrac = 1'b0;
    case (opcode)
      exec_pkg::OP_ADD_CARRY: aluCin = s.sreg[exec_pkg::FLAG_C];
      exec_pkg::OP_SUB_REGS, exec_pkg::OP_SUB_CONST, exec_pkg::OP_COMPARE_REGS,
      exec_pkg::OP_COMPARE_IMM: aluSub = 1'b1;
      exec_pkg::OP_SUB_REGS_BORROW, exec_pkg::OP_SUB_CONST_BORROW,
      exec_pkg::OP_COMPARE_BORROW: begin
        aluSub = 1'b1;
        aluCin = s.sreg[exec_pkg::FLAG_C];
      end
      exec_pkg::OP_MULT_SIGNED, exec_pkg::OP_FRAC_MULT_SIGNED: begin
        mulASigned = 1'b1;
        mulBSigned = 1'b1;
      end
      exec_pkg::OP_MULT_MIXED, exec_pkg::OP_FRAC_MULT_MIXED: mulASigned = 1'b1;
      default: ;
    endcase
    if (opcode == exec_pkg::OP_FRAC_MULT_UNSIGNED || opcode == exec_pkg::OP_FRAC_MULT_SIGNED ||
        opcode == exec_pkg::OP_FRAC_MULT_MIXED) begin
      mulFrac = 1'b1;
    end
  end

  // Word arithmetic and bitwise results
  always_comb begin
    pairIn = {rdHigh, rd};
    wordK = 16'(rr[exec_pkg::WORD_K_W-1:0]);
    wordRes = (opcode == exec_pkg::OP_WORD_SUB_IMM) ? pairIn - wordK : pairIn + wordK;
    case (opcode)
      exec_pkg::OP_BITAND_REGS, exec_pkg::OP_BITAND_CONST: logicRes = rd & rr;
      exec_pkg::OP_BITOR_REGS, exec_pkg::OP_BITOR_CONST, exec_pkg::OP_BITS_SET:
        logicRes = rd | rr;
      exec_pkg::OP_BITXOR_REGS: logicRes = rd ^ rr;
      exec_pkg::OP_BITS_CLEAR: logicRes = rd & (exec_pkg::ALL_ONES - rr);
      default: logicRes = rd & rd;
    endcase
  end

  // Decode of result, flags, cycle count and next program counter
  always_comb begin
    logic skip;
    logic zBorrow;
    logic wv;
    logic wc;
    skip = 1'b0;
    zBorrow = (aluRes == 8'h00) && s.sreg[exec_pkg::FLAG_Z];
    wv = 1'b0;
    wc = 1'b0;
    dec = '0;
    dec.kind = exec_pkg::WB_NONE;
    dec.mask = exec_pkg::MASK_NONE;
    dec.pc = s.pc + exec_pkg::PC_STEP_ONE;
    dec.ret = s.pc + exec_pkg::PC_STEP_ONE;
    decCyc = exec_pkg::CYC_ONE;
    case (opcode)
      exec_pkg::OP_ADD_REGS, exec_pkg::OP_ADD_CARRY, exec_pkg::OP_SUB_REGS,
      exec_pkg::OP_SUB_CONST: begin
        dec.kind = exec_pkg::WB_BYTE;
        dec.data = 16'(aluRes);
        dec.mask = exec_pkg::MASK_ARITH;
        dec.vals = exec_pkg::mk_flags(aluH, 1'b0, aluV, aluRes[7], aluRes == 8'h00, aluC);
      end
      exec_pkg::OP_SUB_REGS_BORROW, exec_pkg::OP_SUB_CONST_BORROW: begin
        dec.kind = exec_pkg::WB_BYTE;
        dec.data = 16'(aluRes);
        dec.mask = exec_pkg::MASK_ARITH;
        dec.vals = exec_pkg::mk_flags(aluH, 1'b0, aluV, aluRes[7], zBorrow, aluC);
      end
      exec_pkg::OP_COMPARE_REGS, exec_pkg::OP_COMPARE_IMM: begin
        dec.mask = exec_pkg::MASK_ARITH;
        dec.vals = exec_pkg::mk_flags(aluH, 1'b0, aluV, aluRes[7], aluRes == 8'h00, aluC);
      end
      exec_pkg::OP_COMPARE_BORROW: begin
        dec.mask = exec_pkg::MASK_ARITH;
        dec.vals = exec_pkg::mk_flags(aluH, 1'b0, aluV, aluRes[7], zBorrow, aluC);
      end
      exec_pkg::OP_WORD_ADD_IMM, exec_pkg::OP_WORD_SUB_IMM: begin
        if (opcode == exec_pkg::OP_WORD_ADD_IMM) begin
          wv = !rdHigh[7] && wordRes[15];
          wc = !wordRes[15] && rdHigh[7];
        end else begin
          wv = rdHigh[7] && !wordRes[15];
          wc = wordRes[15] && !rdHigh[7];
        end
        dec.kind = exec_pkg::WB_PAIR;
        dec.data = wordRes;
        dec.mask = exec_pkg::MASK_WORD;
        dec.vals = exec_pkg::mk_flags(1'b0, wordRes[15] ^ wv, wv, wordRes[15],
                                      wordRes == 16'h0000, wc);
        decCyc = exec_pkg::CYC_TWO;
      end
      exec_pkg::OP_BITAND_REGS, exec_pkg::OP_BITAND_CONST, exec_pkg::OP_BITOR_REGS,
      exec_pkg::OP_BITOR_CONST, exec_pkg::OP_BITXOR_REGS, exec_pkg::OP_BITS_SET,
      exec_pkg::OP_BITS_CLEAR, exec_pkg::OP_ZERO_MINUS_TEST: begin
        dec.kind = exec_pkg::WB_BYTE;
        dec.data = 16'(logicRes);
        dec.mask = exec_pkg::MASK_LOGIC;
        dec.vals = exec_pkg::mk_flags(1'b0, 1'b0, 1'b0, logicRes[7], logicRes == 8'h00, 1'b0);
      end
      exec_pkg::OP_MULT_UNSIGNED, exec_pkg::OP_MULT_SIGNED, exec_pkg::OP_MULT_MIXED,
      exec_pkg::OP_FRAC_MULT_UNSIGNED, exec_pkg::OP_FRAC_MULT_SIGNED,
      exec_pkg::OP_FRAC_MULT_MIXED: begin
        dec.kind = exec_pkg::WB_PROD;
        dec.data = mulProd;
        dec.mask = exec_pkg::MASK_MULT;
        dec.vals = exec_pkg::mk_flags(1'b0, 1'b0, 1'b0, 1'b0, mulZ, mulC);
        decCyc = exec_pkg::CYC_TWO;
      end
      exec_pkg::OP_INDIRECT_JUMP: begin
        dec.pc = zPtr;
        decCyc = exec_pkg::CYC_TWO;
      end
      exec_pkg::OP_INDIRECT_CALL: begin
        dec.pc = zPtr;
        dec.push = 1'b1;
        decCyc = exec_pkg::CYC_THREE;
      end
      exec_pkg::OP_COMPARE_SKIP_EQUAL: skip = (rd == rr);
      exec_pkg::OP_SKIP_BIT_CLEAR: skip = !rr[bitSel];
      exec_pkg::OP_SKIP_BIT_SET: skip = rr[bitSel];
      default: ;
    endcase
    // Skip length follows the size of the instruction jumped over
    if (skip) begin
      decCyc = nextIsTwoWord ? exec_pkg::CYC_THREE : exec_pkg::CYC_TWO;
      dec.pc = s.pc + (nextIsTwoWord ? exec_pkg::PC_STEP_THREE : exec_pkg::PC_STEP_TWO);
    end
  end

  // Sequencing, retirement and register port
  always_comb begin
    logic retire;
    retire = 1'b0;
    next_s = s;
    next_s.wbValid = 1'b0;
    next_s.pushValid = 1'b0;
    next_s.regRdata = 8'h00;
    fin = s.busy ? s.pend : dec;
    if (regWr) begin
      case (regAddr)
        exec_pkg::REG_SREG: next_s.sreg = regWdata;
        exec_pkg::REG_CTRL: next_s.ctrl = regWdata;
        default: ;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        exec_pkg::REG_SREG: next_s.regRdata = s.sreg;
        exec_pkg::REG_CTRL: next_s.regRdata = s.ctrl;
        exec_pkg::REG_PC_LO: next_s.regRdata = s.pc[7:0];
        exec_pkg::REG_PC_HI: next_s.regRdata = s.pc[15:8];
        default: next_s.regRdata = 8'h00;
      endcase
    end
    if (s.busy) begin
      next_s.cnt = s.cnt - 2'h1;
      retire = (s.cnt == exec_pkg::CYC_ONE);
      next_s.busy = !retire;
    end else if (take) begin
      next_s.pend = dec;
      next_s.cnt = decCyc - 2'h1;
      retire = (decCyc == exec_pkg::CYC_ONE);
      next_s.busy = !retire;
    end
    // Flag updates from retirement win over a software write
    if (retire) begin
      next_s.wbValid = (fin.kind != exec_pkg::WB_NONE);
      next_s.wbKind = fin.kind;
      next_s.wbData = fin.data;
      next_s.sreg = (next_s.sreg & ~fin.mask) | (fin.vals & fin.mask);
      next_s.pc = fin.pc;
      next_s.pushValid = fin.push;
      next_s.pushAddr = fin.ret;
    end
    next_s.ready = !next_s.busy && !next_s.ctrl[exec_pkg::CTRL_HALT];
  end

  // State register
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      s <= '0;
      s.sreg <= exec_pkg::SREG_RESET;
      s.ctrl <= exec_pkg::CTRL_RESET;
      s.pc <= exec_pkg::PC_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign ready = s.ready;
  assign wbValid = s.wbValid;
  assign wbKind = s.wbKind;
  assign wbData = s.wbData;
  assign pc = s.pc;
  assign sreg = s.sreg;
  assign pushValid = s.pushValid;
  assign pushAddr = s.pushAddr;
  assign regRdata = s.regRdata;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync);

  sequence twoCycleDone;
    !ready ##1 wbValid;
  endsequence

  sequence threeCycleDone;
    !ready ##1 !ready ##1 pushValid;
  endsequence

  add_result_a: assert property (take && opcode == exec_pkg::OP_ADD_REGS |=>
    wbValid && wbData[7:0] == 8'($past(rd) + $past(rr)))
    else $error("add result wrong");
  word_add_a: assert property (take && opcode == exec_pkg::OP_WORD_ADD_IMM |=>
    twoCycleDone ##0 wbKind == exec_pkg::WB_PAIR)
    else $error("word add timing wrong");
  word_sub_a: assert property (take && opcode == exec_pkg::OP_WORD_SUB_IMM |->
    ##2 wbData == 16'({$past(rdHigh, 2), $past(rd, 2)} - 16'($past(rr[5:0], 2))))
    else $error("word subtract wrong");
  sub_carry_a: assert property (take && opcode == exec_pkg::OP_SUB_REGS |=>
    sreg[exec_pkg::FLAG_C] == ($past(rd) < $past(rr)))
    else $error("subtract borrow wrong");
  logic_flags_a: assert property (take && opcode == exec_pkg::OP_BITXOR_REGS |=>
    !sreg[exec_pkg::FLAG_V] && sreg[exec_pkg::FLAG_C] == $past(sreg[exec_pkg::FLAG_C]))
    else $error("logic flags wrong");
  clear_bits_a: assert property (take && opcode == exec_pkg::OP_BITS_CLEAR |=>
    wbData[7:0] == ($past(rd) & ~$past(rr)))
    else $error("bit clear wrong");
  mult_result_a: assert property (take && opcode == exec_pkg::OP_MULT_UNSIGNED |=>
    twoCycleDone ##0 wbKind == exec_pkg::WB_PROD &&
    wbData == 16'($past(rd, 2)) * 16'($past(rr, 2)))
    else $error("multiply wrong");
  jump_pc_a: assert property (take && opcode == exec_pkg::OP_INDIRECT_JUMP |->
    ##2 pc == $past(zPtr, 2) && !wbValid)
    else $error("indirect jump wrong");
  call_push_a: assert property (take && opcode == exec_pkg::OP_INDIRECT_CALL |=>
    threeCycleDone ##0 pc == $past(zPtr, 3) && pushAddr == 16'($past(pc, 3) + 16'h0001))
    else $error("indirect call wrong");
  skip_long_a: assert property (take && opcode == exec_pkg::OP_SKIP_BIT_SET &&
    rr[bitSel] && nextIsTwoWord |=> !ready ##1 !ready ##1 pc == 16'($past(pc, 3) + 16'h0003))
    else $error("skip length wrong");
endmodule : exec_unit

// File: sim/exec_feeder.sv
// Purpose: Decoder and operand fetch stand-in that feeds the execute stage.
// Assumes: Caller calls put just after a rising edge.
// Notes: rd, rr, rdHigh and zPtr flip to junk whenever issue is dropped.
module exec_feeder (
  // Clock
  input wire logic clk,
  // Issue side
  output logic issue,
  output exec_pkg::op_e opcode,
  output logic [7:0] rd,
  output logic [7:0] rr,
  output logic [7:0] rdHigh,
  output logic [15:0] zPtr,
  output logic [2:0] bitSel,
  output logic nextIsTwoWord
);
  timeunit 1ns;
  timeprecision 1ns;

  // Quiet lines at time zero
  initial begin
    issue = 1'b0;
    opcode = exec_pkg::OP_NOP;
    {rd, rr, rdHigh, zPtr, bitSel, nextIsTwoWord} = '0;
  end

  // Present one instruction with its operands
  task automatic put(input exec_pkg::op_e op, input logic [7:0] a, b, h,
                     input logic [15:0] z, input logic [2:0] s, input logic t);
    issue <= 1'b1;
    opcode <= op;
    rd <= a;
    rr <= b;
    rdHigh <= h;
    zPtr <= z;
    bitSel <= s;
    nextIsTwoWord <= t;
  endtask : put

  // Drop issue; stale operands must not be trusted
  task automatic rest();
    issue <= 1'b0;
    rd <= ~rd;
    rr <= ~rr;
    rdHigh <= ~rdHigh;
    zPtr <= ~zPtr;
  endtask : rest
endmodule : exec_feeder

// File: sim/tb_exec_unit.sv
// Purpose: Self-checking bench for the execute stage.
// Assumes: Results are sampled half a cycle after retirement.
// Notes: Expected flags and pc are tracked here from the instruction behaviour.
module tb_exec_unit;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 4000;
  typedef struct packed {
    exec_pkg::wb_e kind;
    logic [15:0] data;
  } note_s;
  logic clk, nrst, issue, nextIsTwoWord, regWr, regRd, ready, wbValid, pushValid;
  exec_pkg::op_e opcode;
  exec_pkg::wb_e wbKind;
  logic [7:0] rd, rr, rdHigh, regWdata, regRdata, sreg, expSreg, a, b;
  logic [15:0] zPtr, wbData, pc, pushAddr, expPc;
  logic [2:0] bitSel;
  logic [1:0] regAddr;
  logic pending, expWb, expPush;
  integer seed = 32'h6682;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  note_s noteQ[$];
  note_s nt;
  logic [15:0] pushQ[$];

  exec_unit dut (.clk(clk), .nrst(nrst), .issue(issue), .opcode(opcode), .rd(rd), .rr(rr),
    .rdHigh(rdHigh), .zPtr(zPtr), .bitSel(bitSel), .nextIsTwoWord(nextIsTwoWord),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .ready(ready), .wbValid(wbValid), .wbKind(wbKind),
    .wbData(wbData), .pc(pc), .sreg(sreg), .pushValid(pushValid), .pushAddr(pushAddr));
  exec_feeder far (.clk(clk), .issue(issue), .opcode(opcode), .rd(rd), .rr(rr),
    .rdHigh(rdHigh), .zPtr(zPtr), .bitSel(bitSel), .nextIsTwoWord(nextIsTwoWord));

  // Clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Register port master
  task automatic reg_write(input logic [1:0] ad, input logic [7:0] d);
    regAddr <= ad;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk); // Edge between strobes
  endtask : reg_write

  task automatic reg_read(input logic [1:0] ad, input logic [7:0] exp);
    regAddr <= ad;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    check(16'(regRdata), 16'(exp));
    @(posedge clk);
  endtask : reg_read

  task automatic wait_ready();
    for (int i = 0; i < 8 && ready !== 1'b1; i++) @(negedge clk);
    check(16'(ready), 16'h0001);
    @(posedge clk);
  endtask : wait_ready

  // Reference behaviour of one instruction
  task automatic predict(input exec_pkg::op_e op, input logic [7:0] x, y, h,
                         input logic [15:0] z, input logic [2:0] bs, input logic tw,
                         output int n);
    logic [7:0] r, f, m;
    logic [15:0] w;
    logic signed [17:0] pp;
    logic ci, cy, hc, v, sa, sb, hit, chain, zk;
    exec_pkg::wb_e k;
    {r, f, m, w, cy, hc, v, hit} = '0;
    n = 1;
    k = exec_pkg::WB_BYTE;
    expWb = 1'b1;
    expPush = 1'b0;
    chain = op inside {exec_pkg::OP_SUB_REGS_BORROW, exec_pkg::OP_SUB_CONST_BORROW,
                       exec_pkg::OP_COMPARE_BORROW};
    ci = (chain || op == exec_pkg::OP_ADD_CARRY) && expSreg[exec_pkg::FLAG_C];
    zk = !chain || expSreg[exec_pkg::FLAG_Z];
    case (op) inside
      [exec_pkg::OP_ADD_REGS:exec_pkg::OP_ADD_CARRY]: begin
        {cy, r} = {1'b0, x} + {1'b0, y} + 9'(ci);
        hc = int'(x[3:0]) + int'(y[3:0]) + int'(ci) > 15;
        v = (x[7] == y[7]) && (r[7] != x[7]);
        m = 8'h2f;
      end
      [exec_pkg::OP_WORD_ADD_IMM:exec_pkg::OP_WORD_SUB_IMM]: begin
        sa = op == exec_pkg::OP_WORD_SUB_IMM;
        w = sa ? {h, x} - {10'h000, y[5:0]} : {h, x} + {10'h000, y[5:0]};
        v = sa ? h[7] & ~w[15] : ~h[7] & w[15];
        cy = sa ? w[15] & ~h[7] : h[7] & ~w[15];
        f = {3'b000, w[15] ^ v, v, w[15], (w == 16'h0000), cy};
        m = 8'h1f;
        n = 2;
        k = exec_pkg::WB_PAIR;
      end
      [exec_pkg::OP_SUB_REGS:exec_pkg::OP_SUB_CONST_BORROW],
      [exec_pkg::OP_COMPARE_REGS:exec_pkg::OP_COMPARE_IMM]: begin
        {cy, r} = {1'b0, x} - {1'b0, y} - 9'(ci);
        hc = int'(x[3:0]) < int'(y[3:0]) + int'(ci);
        v = (x[7] != y[7]) && (r[7] != x[7]);
        m = 8'h2f;
        expWb = op < exec_pkg::OP_COMPARE_REGS;
      end
      [exec_pkg::OP_BITAND_REGS:exec_pkg::OP_ZERO_MINUS_TEST]: begin
        case (op)
          exec_pkg::OP_BITAND_REGS, exec_pkg::OP_BITAND_CONST: r = x & y;
          exec_pkg::OP_BITXOR_REGS: r = x ^ y;
          exec_pkg::OP_BITS_CLEAR: r = x & (8'hff - y);
          exec_pkg::OP_ZERO_MINUS_TEST: r = x & x;
          default: r = x | y;
        endcase
        m = 8'h0e;
      end
      [exec_pkg::OP_MULT_UNSIGNED:exec_pkg::OP_FRAC_MULT_MIXED]: begin
        sa = !(op inside {exec_pkg::OP_MULT_UNSIGNED, exec_pkg::OP_FRAC_MULT_UNSIGNED});
        sb = op inside {exec_pkg::OP_MULT_SIGNED, exec_pkg::OP_FRAC_MULT_SIGNED};
        pp = $signed({sa & x[7], x}) * $signed({sb & y[7], y});
        w = op > exec_pkg::OP_MULT_MIXED ? {pp[14:0], 1'b0} : pp[15:0];
        f = {6'h00, (w == 16'h0000), pp[15]};
        m = 8'h03;
        n = 2;
        k = exec_pkg::WB_PROD;
      end
      [exec_pkg::OP_INDIRECT_JUMP:exec_pkg::OP_INDIRECT_CALL]: begin
        expWb = 1'b0;
        expPush = op == exec_pkg::OP_INDIRECT_CALL;
        n = expPush ? 3 : 2;
        if (expPush) pushQ.push_back(expPc + 16'h0001);
      end
      default: begin
        expWb = 1'b0;
        hit = op == exec_pkg::OP_COMPARE_SKIP_EQUAL ? x == y
            : y[bs] == (op == exec_pkg::OP_SKIP_BIT_SET);
        n = hit ? (tw ? 3 : 2) : 1;
      end
    endcase
    if (m == 8'h2f || m == 8'h0e) f = {2'b00, hc, 1'b0, v, r[7], (r == 8'h00 && zk), cy};
    expSreg = (expSreg & ~m) | (f & m);
    expPc = op inside {exec_pkg::OP_INDIRECT_JUMP, exec_pkg::OP_INDIRECT_CALL} ? z
          : expPc + 16'(hit ? n : 1);
    if (expWb) noteQ.push_back('{k, k == exec_pkg::WB_BYTE ? {8'h00, r} : w});
  endtask : predict

  // State check of the last retired instruction
  task automatic settle();
    if (pending) begin
      @(negedge clk);
      check(pc, expPc);
      check(16'(sreg), 16'(expSreg));
      check(16'({wbValid, pushValid, ready}), 16'({expWb, expPush, 1'b1}));
      pending = 1'b0;
    end
  endtask : settle

  // Issue one instruction, optionally after idle cycles
  task automatic send(input exec_pkg::op_e op, input logic [7:0] x, y, input int gap);
    int n;
    logic [7:0] h;
    logic [15:0] z;
    logic [2:0] bs;
    logic tw;
    h = 8'($random(seed));
    z = 16'($random(seed));
    bs = 3'($random(seed));
    tw = 1'($random(seed));
    if (gap > 0) begin
      far.rest();
      settle();
      repeat (gap) @(posedge clk);
    end
    far.put(op, x, y, h, z, bs, tw);
    settle();
    predict(op, x, y, h, z, bs, tw, n);
    @(posedge clk);
    if (n > 1) begin
      far.rest();
      repeat (n - 1) begin
        @(negedge clk);
        check(16'({ready, wbValid}), 16'h0000);
        @(posedge clk);
      end
    end
    pending = 1'b1;
  endtask : send

  // Pair each write-back or push pulse with its oldest note
  always @(negedge clk) begin
    if (wbValid === 1'b1) begin
      if (noteQ.size() == 0) check(16'h0001, 16'h0000);
      else begin
        nt = noteQ.pop_front();
        check(16'(wbKind), 16'(nt.kind));
        check(nt.kind == exec_pkg::WB_BYTE ? {8'h00, wbData[7:0]} : wbData, nt.data);
      end
    end
    if (pushValid === 1'b1) begin
      if (pushQ.size() == 0) check(16'h0001, 16'h0000);
      else check(pushAddr, pushQ.pop_front());
    end
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    {regAddr, regWdata, regWr, regRd, pending, expPc, expSreg} = '0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    wait_ready();
    for (int i = 0; i < 4; i++) reg_read(2'(i), 8'h00);
    reg_write(2'h2, 8'h55);
    reg_write(2'h0, 8'hc0);
    expSreg = 8'hc0;
    reg_read(2'h2, 8'h00);
    reg_read(2'h0, 8'hc0);
    for (int k = 0; k < 6; k++) begin
      for (int o = 1; o <= int'(exec_pkg::OP_SKIP_BIT_SET); o++) begin
        a = k == 0 ? 8'h80 : 8'($random(seed));
        b = k == 0 ? 8'h80 : k == 1 ? a : 8'($random(seed));
        send(exec_pkg::op_e'(o), a, b, k > 3 ? int'(2'($random(seed))) : 0);
      end
    end
    far.rest();
    settle();
    @(posedge clk);
    // Halted core must ignore an issue
    reg_write(2'h1, 8'h01);
    reg_read(2'h1, 8'h01);
    far.put(exec_pkg::OP_ADD_REGS, 8'h01, 8'h01, 8'h00, 16'h0000, 3'h0, 1'b0);
    @(posedge clk);
    far.rest();
    @(negedge clk);
    check(16'(ready), 16'h0000);
    check(pc, expPc);
    @(posedge clk);
    reg_write(2'h1, 8'h00);
    wait_ready();
    reg_read(2'h2, expPc[7:0]);
    reg_read(2'h3, expPc[15:8]);
    reg_read(2'h0, expSreg);
    check(16'(noteQ.size() + pushQ.size()), 16'h0000);
    print_verdict();
  end
endmodule : tb_exec_unit
